/* common/dscl_map.vh */
// Purpose: constants for the serial command latch controller of an 8-bit multi-channel DAC
// Assumes: included by bare name from the design files
// Notes: command byte field positions are defaults that the top module exposes as parameters
`ifndef DSCL_MAP_VH
`define DSCL_MAP_VH

// fixed upper four bits of the 7-bit slave address
`define DSCL_ADDR_HI 4'h5
// read/write flag value that this receive-only device accepts
`define DSCL_ADDR_WRITE 1'b0

// default channel count (4 or 8)
`define DSCL_CHANNELS 8
// default channel-select field low bit, three bits wide
`define DSCL_CMD_SEL_LSB 0
// default power-down bit position
`define DSCL_CMD_PD_POS 3
// default latch-clear bit position
`define DSCL_CMD_CLR_POS 4
// default reserved field low bit, three bits wide
`define DSCL_CMD_RSV_LSB 5

// reset value of every input and output latch
`define DSCL_CODE_RST 8'h00
// reset value of the power-down state
`define DSCL_PD_RST 1'b0

// bit counter values: last data bit index and acknowledge clock index
`define DSCL_BIT_LAST 4'h7
`define DSCL_BIT_ACK 4'h8

`endif

/* verilog/dscl_latch_bank.v */
// Purpose: per-channel input and output latches of the DAC, double buffered
// Assumes: all strobes are one-cycle pulses on clock_i from the controller
// Notes: output latches are registers, so the DAC codes come straight from flip-flops
`include "dscl_map.vh"

module dscl_latch_bank #(
    parameter CHANNELS = `DSCL_CHANNELS
) (
    input wire clock_i,
    input wire rst_i,
    input wire wr_i,
    input wire [2:0] wr_chan_i,
    input wire [7:0] wr_data_i,
    input wire clr_i,
    input wire xfer_i,
    output wire [CHANNELS*8-1:0] code_o
);

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            reg [7:0] in_latch;
            reg [7:0] out_latch;
            localparam [2:0] CH_IDX = ch; // channel number at select width
            // input latch: clear wins over a write, writes only the selected channel
            always @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    in_latch <= `DSCL_CODE_RST;
                end else if (clr_i) begin
                    in_latch <= `DSCL_CODE_RST;
                end else if (wr_i && (wr_chan_i == CH_IDX)) begin
                    in_latch <= wr_data_i;
                end
            end
            // output latch: every channel copies its input latch in the same cycle
            always @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    out_latch <= `DSCL_CODE_RST;
                end else if (xfer_i) begin
                    out_latch <= in_latch;
                end
            end
            // straight binary unipolar code, output = code * ref / 256
            assign code_o[ch*8 +: 8] = out_latch;
        end
    endgenerate

endmodule // dscl_latch_bank

/* verilog/dscl_ctrl.v */
// Purpose: receive-only two-wire command interpreter feeding double-buffered DAC latches
// Assumes: scl_i, sda_i and the address pins are asynchronous and pass two flip-flops;
//          clock_i is well above eight times the bus clock rate
// Notes: the acknowledge drives sda low with an open-drain style enable, low while driving
//
// Overview of operation
// - latch-clear bit empties all input latches immediately
// - byte after a latch-clear command is dropped
// - later pairs after clear write normally
// - outputs and power state change only at stop
// - bus pins are inputs; acknowledge on ninth clock
// - repeated start keeps input data pending
// - only the addressed device acts on stop
// - pending data moves after later command plus stop
// - stop is seen at any bit position
// - partial command byte at stop is dropped
// - partial output byte dropped, command bits still apply
// - eight-bit straight binary unipolar channel codes
// - four or eight channels by build option
// - channel-select bits pick the written input latch
// - last command power-down bit sets state at stop
// - slave address is 0101 plus pin-set bits
// - lone final command uses only power-down and clear
`include "dscl_map.vh"

module dscl_ctrl #(
    parameter CHANNELS = `DSCL_CHANNELS,
    parameter SEL_LSB = `DSCL_CMD_SEL_LSB,
    parameter PD_POS = `DSCL_CMD_PD_POS,
    parameter CLR_POS = `DSCL_CMD_CLR_POS,
    parameter RSV_LSB = `DSCL_CMD_RSV_LSB
) (
    input wire clock_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_n_o,
    input wire addr_pin_0_i,
    input wire addr_pin_1_i,
    input wire addr_pin_2_i,
    output wire [CHANNELS*8-1:0] dac_code_o,
    output reg power_down_o
);

    // receiver states, one-hot
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_ADDR = 5'b00010;
    localparam [4:0] ST_CMD = 5'b00100;
    localparam [4:0] ST_DATA = 5'b01000;
    localparam [4:0] ST_SKIP = 5'b10000;
    localparam [3:0] NCH = CHANNELS; // channel count at compare width

    reg scl_s1;
    reg scl_s2;
    reg scl_d;
    reg sda_s1;
    reg sda_s2;
    reg sda_d;
    reg [2:0] pin_s1;
    reg [2:0] pin_s2;
    reg [4:0] state;
    reg [3:0] bit_cnt;
    reg [6:0] shift;
    reg ack_pend;
    reg have_cmd;
    reg skip_data;
    reg pd_pend;
    reg [2:0] cmd_sel;
    reg bank_wr;
    reg [2:0] bank_chan;
    reg [7:0] bank_data;
    reg bank_clr;
    reg bank_xfer;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire addressed;
    wire [7:0] rx_byte;
    wire [6:0] my_addr;
    wire [2:0] rx_sel;
    wire [2:0] rsv_bits;

    // two-stage synchronisers for bus pins and address pins
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            pin_s1 <= {addr_pin_2_i, addr_pin_1_i, addr_pin_0_i};
            pin_s2 <= pin_s1;
        end
    end

    // delayed copies of the synchronised lines for edge detection
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s2;
            sda_d <= sda_s2;
        end
    end

    // bus events: clock edges, start and stop while scl is high
    assign scl_rise = scl_s2 & ~scl_d;
    assign scl_fall = ~scl_s2 & scl_d;
    assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign addressed = state[2] | state[3];
    assign rx_byte = {shift, sda_s2};

    // slave address: fixed high nibble, then pins (octal build forces a zero bit)
    assign my_addr = (CHANNELS == 8) ? {`DSCL_ADDR_HI, 1'b0, pin_s2[1:0]} :
                                       {`DSCL_ADDR_HI, pin_s2};

    // command fields at parameter positions; reserved bits are not looked at
    assign rx_sel = rx_byte[SEL_LSB +: 3];
    assign rsv_bits = rx_byte[RSV_LSB +: 3];

    // receiver, command decode and acknowledge
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 7'h00;
            ack_pend <= 1'b0;
            have_cmd <= 1'b0;
            skip_data <= 1'b0;
            pd_pend <= `DSCL_PD_RST;
            cmd_sel <= 3'h0;
            bank_wr <= 1'b0;
            bank_chan <= 3'h0;
            bank_data <= `DSCL_CODE_RST;
            bank_clr <= 1'b0;
            bank_xfer <= 1'b0;
            power_down_o <= `DSCL_PD_RST;
            sda_o <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            bank_wr <= 1'b0;
            bank_clr <= 1'b0;
            bank_xfer <= 1'b0;
            if (start_det) begin
                // new or repeated start: input latches stay as they are
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                have_cmd <= 1'b0;
                skip_data <= 1'b0;
                ack_pend <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else if (stop_det) begin
                // only the device addressed now, with a whole command, applies the stop
                if (addressed && have_cmd) begin
                    bank_xfer <= 1'b1;
                    power_down_o <= pd_pend;
                end
                state <= ST_IDLE;
                bit_cnt <= 4'h0;
                ack_pend <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else begin
                if (scl_rise && !state[0]) begin
                    if (bit_cnt == `DSCL_BIT_ACK) begin
                        bit_cnt <= 4'h0;
                    end else begin
                        shift <= rx_byte[6:0];
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `DSCL_BIT_LAST) begin
                            case (state)
                                ST_ADDR: begin
                                    if (rx_byte[7:1] == my_addr &&
                                        rx_byte[0] == `DSCL_ADDR_WRITE) begin
                                        state <= ST_CMD;
                                        ack_pend <= 1'b1;
                                    end else begin
                                        state <= ST_SKIP;
                                    end
                                end
                                ST_CMD: begin
                                    // last command wins for power-down
                                    pd_pend <= rx_byte[PD_POS];
                                    have_cmd <= 1'b1;
                                    cmd_sel <= rx_sel;
                                    bank_clr <= rx_byte[CLR_POS];
                                    skip_data <= rx_byte[CLR_POS];
                                    state <= ST_DATA;
                                    ack_pend <= 1'b1;
                                end
                                ST_DATA: begin
                                    // a select beyond the channel count writes nothing
                                    if (!skip_data && ({1'b0, cmd_sel} < NCH)) begin
                                        bank_wr <= 1'b1;
                                        bank_chan <= cmd_sel;
                                        bank_data <= rx_byte;
                                    end
                                    skip_data <= 1'b0;
                                    state <= ST_CMD;
                                    ack_pend <= 1'b1;
                                end
                                default: begin
                                    state <= ST_SKIP;
                                end
                            endcase
                        end
                    end
                end
                // pull sda low from the fall after bit 8 until the fall after clock 9
                if (scl_fall) begin
                    if (bit_cnt == `DSCL_BIT_ACK && ack_pend) begin
                        sda_oe_n_o <= 1'b0;
                        ack_pend <= 1'b0;
                    end else if (bit_cnt == 4'h0) begin
                        sda_oe_n_o <= 1'b1;
                    end
                end
            end
        end
    end

    // double-buffered channel latches
    dscl_latch_bank #(
        .CHANNELS(CHANNELS)
    ) u_bank (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_i(bank_wr),
        .wr_chan_i(bank_chan),
        .wr_data_i(bank_data),
        .clr_i(bank_clr),
        .xfer_i(bank_xfer),
        .code_o(dac_code_o)
    );

endmodule // dscl_ctrl

/* sim/dscl_master.sv */
// Purpose: two-wire bus master model driving the dac command controller
// Assumes: steps on clock_i rising edges, eight clocks per bit (160 ns)
// Notes: sda_o high means released; the bench supplies the pull-up
module dscl_master (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack = 1'b0;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // top n bits, msb first; sda moves only while scl is low
    task automatic bits(input logic [7:0] d, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            scl_o <= 1'b0;
            tick(2);
            sda_o <= d[i];
            tick(2);
            scl_o <= 1'b1;
            tick(4);
        end
    endtask
    // ninth clock with sda released, acknowledge read while scl high
    task automatic put(input logic [7:0] d);
        bits(d, 8);
        bits(8'h80, 1);
        ack = ~sda_i;
    endtask
    // a=1,b=0 gives start, a=0,b=1 gives stop; long low phase lets ack end
    task automatic cond(input logic a, input logic b);
        scl_o <= 1'b0;
        tick(6);
        sda_o <= a;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= b;
        tick(4);
    endtask
endmodule // dscl_master

/* sim/dscl_ctrl_asserts.sv */
// Purpose: port-level checks of the dac command controller
// Assumes: bound to every dscl_ctrl instance
// Notes: stop-related checks lean on the bench waiting between frames
module dscl_ctrl_asserts #(
    parameter CHANNELS = 8
) (
    input wire clock_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    input wire [CHANNELS*8-1:0] dac_code_o,
    input wire power_down_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sda_val_low_a: assert property (sda_o == 1'b0)
        else $error("sda drive value not low");
    ack_start_a: assert property ($fell(sda_oe_n_o) |-> !$past(scl_i))
        else $error("ack began with scl high");
    ack_end_a: assert property ($rose(sda_oe_n_o) |-> !$past(scl_i))
        else $error("ack ended with scl high");
    ack_span_a: assert property ($fell(sda_oe_n_o) |->
        !sda_oe_n_o [*6] ##[1:4] sda_oe_n_o) else $error("ack length wrong");
    code_idle_a: assert property ($changed(dac_code_o) |-> scl_i && sda_i)
        else $error("codes moved on busy bus");
    code_stop_a: assert property ($changed(dac_code_o) |-> !$past(sda_i, 8))
        else $error("codes moved without stop");
    pd_stop_a: assert property ($changed(power_down_o) |->
        scl_i && sda_i && !$past(sda_i, 7)) else $error("power state moved without stop");
    rst_vals_a: assert property ($fell(rst_i) |->
        dac_code_o == '0 && !power_down_o && sda_oe_n_o) else $error("bad reset values");
endmodule // dscl_ctrl_asserts
bind dscl_ctrl dscl_ctrl_asserts #(.CHANNELS(CHANNELS)) chk (.clock_i(clock_i),
    .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .dac_code_o(dac_code_o), .power_down_o(power_down_o));

/* sim/test_dscl_ctrl.sv */
// Purpose: self-checking bench of the dac command controller
// Assumes: eight channels, address pins low until the restart scenario
// Notes: sda is a pulled-up wire resolved from master and ack drive
module test_dscl_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic a0 = 1'b0;
    logic a1 = 1'b0;
    logic a2 = 1'b0;
    wire scl;
    wire sda;
    wire m_sda;
    wire sda_o;
    wire sda_oe_n;
    wire [63:0] dac;
    wire pd;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    // pull-up: low while either party drives
    assign sda = m_sda & (sda_oe_n | sda_o);
    dscl_master m (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
    dscl_ctrl uut (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_pin_0_i(a0),
        .addr_pin_1_i(a1), .addr_pin_2_i(a2), .dac_code_o(dac), .power_down_o(pd));
    initial forever #10 clock_i = ~clock_i;
    function automatic logic [7:0] ch(input int n);
        return dac[n*8 +: 8];
    endfunction
    function automatic logic [7:0] cmd(input logic [2:0] s, input logic p, input logic c);
        return {3'b000, c, p, s};
    endfunction
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic sendb(input logic [7:0] b);
        m.put(b);
        chk1("ack", 1'b1, m.ack);
    endtask
    task automatic pair(input logic [7:0] c, input logic [7:0] d);
        sendb(c);
        sendb(d);
    endtask
    task automatic frm_open(input logic [7:0] a);
        m.cond(1'b1, 1'b0);
        sendb(a);
    endtask
    task automatic frm_stop();
        m.cond(1'b0, 1'b1);
        m.tick(3);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // values right after reset
    task automatic sc_reset();
        for (int i = 0; i < 8; i++) chk8("code", 8'h00, ch(i));
        chk1("pd", 1'b0, pd);
        chk1("oe_n", 1'b1, sda_oe_n);
    endtask
    // two writes appear together at stop
    task automatic sc_write();
        frm_open(8'h50);
        pair(cmd(3, 0, 0), 8'ha5);
        pair(cmd(7, 0, 0), 8'h3c);
        chk8("ch3 early", 8'h00, ch(3));
        frm_stop();
        chk8("ch3", 8'ha5, ch(3));
        chk8("ch7", 8'h3c, ch(7));
        chk8("ch0", 8'h00, ch(0));
    endtask
    // clear, dropped byte, then a normal pair
    task automatic sc_clear();
        frm_open(8'h50);
        pair(cmd(2, 0, 1), 8'h77);
        pair(cmd(1, 0, 0), 8'h11);
        chk8("ch3 kept", 8'ha5, ch(3));
        frm_stop();
        chk8("ch3", 8'h00, ch(3));
        chk8("ch7", 8'h00, ch(7));
        chk8("ch2", 8'h00, ch(2));
        chk8("ch1", 8'h11, ch(1));
    endtask
    // power down with data, then wake by a lone command
    task automatic sc_power();
        frm_open(8'h50);
        pair(cmd(0, 1, 0), 8'h42);
        chk1("pd early", 1'b0, pd);
        frm_stop();
        chk1("pd on", 1'b1, pd);
        chk8("ch0", 8'h42, ch(0));
        frm_open(8'h50);
        sendb(cmd(5, 0, 0));
        frm_stop();
        chk1("pd off", 1'b0, pd);
        chk8("ch5", 8'h00, ch(5));
    endtask
    // repeated start to another device leaves data pending
    task automatic sc_restart();
        a1 <= 1'b1;
        frm_open(8'h54);
        pair(cmd(4, 0, 0), 8'h99);
        m.cond(1'b1, 1'b0);
        m.put(8'h50);
        chk1("nack", 1'b0, m.ack);
        m.cond(1'b1, 1'b0);
        m.put(8'h55);
        chk1("nack rd", 1'b0, m.ack);
        frm_stop();
        chk8("ch4 held", 8'h00, ch(4));
        frm_open(8'h54);
        sendb(cmd(0, 0, 0));
        frm_stop();
        chk8("ch4", 8'h99, ch(4));
    endtask
    // stops inside a command byte and inside an output byte
    task automatic sc_early();
        frm_open(8'h54);
        pair(cmd(5, 0, 0), 8'h55);
        m.bits(cmd(6, 1, 1), 5);
        frm_stop();
        chk8("ch5", 8'h55, ch(5));
        chk1("pd", 1'b0, pd);
        frm_open(8'h54);
        sendb(cmd(6, 1, 0));
        m.bits(8'hff, 4);
        frm_stop();
        chk8("ch6", 8'h00, ch(6));
        chk1("pd", 1'b1, pd);
        frm_open(8'h54);
        sendb(cmd(0, 0, 1));
        frm_stop();
        chk8("ch5 clr", 8'h00, ch(5));
        chk1("pd", 1'b0, pd);
        // pin 0 moves the address, pin 2 is a fixed zero in the octal build
        a0 <= 1'b1;
        a2 <= 1'b1;
        frm_open(8'h56);
        frm_stop();
    endtask
    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        m.tick(4);
        sc_reset();
        sc_write();
        sc_clear();
        sc_power();
        sc_restart();
        sc_early();
        print_verdict();
    end
endmodule // test_dscl_ctrl
